/* logic/fsp_protect.sv */
// Flash option, security, key compare and block protection logic
`timescale 1ns/1ns
`default_nettype none
module fsp_protect #(
    parameter int MEM_KBYTES = 60
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_dbg,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] nonvolatile_option_byte,
    input wire logic [7:0] nonvolatile_protection_byte,
    input wire logic [63:0] stored_backdoor_key,
    input wire fsp_pkg::fsp_flash_wr_t flash_wr,
    output logic cmd_first_step,
    input wire fsp_pkg::fsp_cmd_t cmd,
    output logic cmd_accept,
    input wire logic blank_ok,
    input wire logic mem_rd,
    input wire logic mem_rd_from_flash,
    input wire logic mem_rd_src_unsecured,
    output logic mem_rd_deny,
    output logic flash_rd_invalid,
    input wire logic vec_req,
    input wire logic [15:0] vec_addr,
    output logic [15:0] vec_addr_out,
    output logic secure
);
    import fsp_pkg::*;

    // ------------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------------
    logic loaded_q;
    logic [7:0] option_q;
    logic [7:0] config_q;
    logic [7:0] protect_q;
    logic viol_q;
    logic lift_q;
    logic key_unlock;
    logic viol_set;
    logic [7:0] rdata_q;
    logic [15:0] vec_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= 1'b1;
        end
    end

    // Copy happens on the first edge after release, never under reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            option_q <= OPTION_RST;
        end else if (!loaded_q) begin
            option_q <= nonvolatile_option_byte & OPTION_MASK;
        end else if (key_unlock || blank_ok) begin
            option_q[1:0] <= SEC_UNSECURED;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            protect_q <= PROTECT_RST;
        end else if (!loaded_q) begin
            protect_q <= nonvolatile_protection_byte & PROTECT_MASK;
        end else if (reg_wr && reg_dbg && reg_addr == OFS_PROTECT) begin
            protect_q <= reg_wdata & PROTECT_MASK;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            config_q <= CONFIG_RST;
        end else if (reg_wr && reg_addr == OFS_CONFIG) begin
            config_q <= reg_wdata & CONFIG_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Security state
    // ------------------------------------------------------------------
    logic key_en;
    logic no_redir;
    logic key_acc;
    logic open_bit;
    logic prot_dis;
    logic [2:0] size_code;
    logic [2:0] size_eff;

    assign key_en = option_q[KEY_EN_BIT];
    assign no_redir = option_q[NORED_BIT];
    assign key_acc = config_q[KEY_ACC_BIT];
    assign open_bit = protect_q[OPEN_BIT];
    assign prot_dis = protect_q[PDIS_BIT];
    assign size_code = protect_q[SIZE_LSB +: 3];

    assign secure = option_q[1:0] != SEC_UNSECURED;

    assign mem_rd_deny = mem_rd && secure && mem_rd_src_unsecured;
    assign flash_rd_invalid = mem_rd && mem_rd_from_flash && key_acc;

    // ------------------------------------------------------------------
    // Backdoor key comparison
    // ------------------------------------------------------------------
    logic [2:0] key_idx_q;
    logic key_bad_q;
    logic key_hit;
    logic key_wr;
    logic byte_ok;

    assign key_hit = flash_wr.addr >= KEY_BASE && flash_wr.addr <= KEY_LAST;
    assign key_wr = flash_wr.wr && key_acc && key_hit && key_en
        && !flash_wr.dbg;
    assign byte_ok = flash_wr.addr[2:0] == key_idx_q
        && flash_wr.data == stored_backdoor_key[{key_idx_q, 3'h0} +: 8];
    assign key_unlock = key_wr && key_idx_q == KEY_LAST_IDX
        && !key_bad_q && byte_ok;
    assign cmd_first_step = flash_wr.wr && !(key_acc && key_hit);

    // Leaving key mode restarts the sequence so stale bytes never count
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            key_idx_q <= 3'h0;
            key_bad_q <= 1'b0;
        end else if (!key_acc) begin
            key_idx_q <= 3'h0;
            key_bad_q <= 1'b0;
        end else if (key_wr) begin
            key_idx_q <= key_idx_q + 3'h1;
            key_bad_q <= (key_idx_q == KEY_LAST_IDX) ? 1'b0
                : (key_bad_q || !byte_ok);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lift_q <= 1'b0;
        end else if (key_unlock) begin
            lift_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Protected range
    // ------------------------------------------------------------------
    logic [15:0] block_size;
    logic [15:0] prot_base;
    logic in_block;
    logic cmd_bad;

    // Sizes a part cannot hold fall back to protecting all flash
    always_comb begin
        size_eff = size_code;
        if ((size_code == SIZE_16K && MEM_KBYTES < 32)
            || (size_code == SIZE_32K && MEM_KBYTES < 60)) begin
            size_eff = SIZE_WHOLE;
        end
    end

    assign block_size = BLOCK_MIN << size_eff;
    assign prot_base = (size_eff == SIZE_WHOLE) ? WHOLE_BASE
        : 16'(16'h0000 - block_size);
    assign in_block = !prot_dis && cmd.addr >= prot_base;

    assign cmd_bad = !open_bit || in_block || (cmd.mass && !prot_dis);
    assign cmd_accept = cmd.valid && !cmd_bad;
    assign viol_set = cmd.valid && cmd_bad;

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            viol_q <= 1'b0;
        end else if (viol_set) begin
            viol_q <= 1'b1;
        end else if (reg_wr && reg_addr == OFS_STATUS
            && reg_wdata[VIOL_BIT]) begin
            viol_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Vector redirection
    // ------------------------------------------------------------------
    logic redir;

    assign redir = open_bit && !no_redir && size_eff != SIZE_WHOLE
        && vec_addr >= VEC_LO && vec_addr <= VEC_HI;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vec_q <= 16'h0000;
        end else if (vec_req) begin
            vec_q <= redir ? 16'(vec_addr - block_size) : vec_addr;
        end
    end
    assign vec_addr_out = vec_q;

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_OPTION: rdata_q <= option_q & OPTION_MASK;
                OFS_CONFIG: rdata_q <= config_q & CONFIG_MASK;
                OFS_PROTECT: rdata_q <= protect_q & PROTECT_MASK;
                OFS_STATUS: begin
                    rdata_q <= 8'h00;
                    rdata_q[VIOL_BIT] <= viol_q;
                    rdata_q[LIFT_BIT] <= lift_q;
                    rdata_q[SECURE_BIT] <= secure;
                end
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_rd_opt;
        reg_rd && reg_addr == OFS_OPTION ##1 1'b1;
    endsequence

    property p_load;
        @(posedge clock) disable iff (!rst_n)
        $rose(loaded_q) |-> option_q == ($past(nonvolatile_option_byte)
            & OPTION_MASK) && protect_q == ($past(
            nonvolatile_protection_byte) & PROTECT_MASK);
    endproperty
    a_load: assert property (p_load) else $error("nv load wrong");

    property p_opt_zero;
        @(posedge clock) disable iff (!rst_n)
        s_rd_opt |-> reg_rdata[5:2] == 4'h0;
    endproperty
    a_opt_zero: assert property (p_opt_zero) else $error("opt rsvd");

    property p_opt_ro;
        @(posedge clock) disable iff (!rst_n)
        loaded_q && reg_wr && reg_addr == OFS_OPTION && !key_unlock
            && !blank_ok |=> $stable(option_q);
    endproperty
    a_opt_ro: assert property (p_opt_ro) else $error("opt written");

    property p_key_refuse;
        @(posedge clock) disable iff (!rst_n)
        $rose(lift_q) |-> $past(key_en) && $past(key_acc)
            && !$past(flash_wr.dbg);
    endproperty
    a_key_refuse: assert property (p_key_refuse)
        else $error("bad unlock");

    property p_lift;
        @(posedge clock) disable iff (!rst_n)
        key_unlock |=> lift_q && !secure ##1 lift_q;
    endproperty
    a_lift: assert property (p_lift) else $error("lift lost");

    property p_deny;
        @(posedge clock) disable iff (!rst_n)
        mem_rd && mem_rd_src_unsecured && option_q[1:0] != SEC_UNSECURED
            |-> mem_rd_deny;
    endproperty
    a_deny: assert property (p_deny) else $error("read leak");

    property p_cfg;
        @(posedge clock) disable iff (!rst_n)
        reg_rd && reg_addr == OFS_CONFIG |=> reg_rdata[4:0] == 5'h00;
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg rsvd");

    property p_cfg_rw;
        @(posedge clock) disable iff (!rst_n)
        reg_wr && reg_addr == OFS_CONFIG
            |=> config_q == ($past(reg_wdata) & CONFIG_MASK);
    endproperty
    a_cfg_rw: assert property (p_cfg_rw) else $error("cfg lost");

    property p_unsec;
        @(posedge clock) disable iff (!rst_n)
        loaded_q && blank_ok |=> option_q[1:0] == SEC_UNSECURED && !secure;
    endproperty
    a_unsec: assert property (p_unsec) else $error("still secure");

    property p_prot_user;
        @(posedge clock) disable iff (!rst_n)
        loaded_q && reg_wr && !reg_dbg |=> $stable(protect_q);
    endproperty
    a_prot_user: assert property (p_prot_user)
        else $error("user wrote prot");

    property p_viol;
        @(posedge clock) disable iff (!rst_n)
        cmd.valid && (!open_bit || (!prot_dis && cmd.addr >= prot_base))
            |-> !cmd_accept ##1 viol_q;
    endproperty
    a_viol: assert property (p_viol) else $error("no violation");

    property p_noredir;
        @(posedge clock) disable iff (!rst_n)
        vec_req && (!open_bit || no_redir || vec_addr > VEC_HI)
            |=> vec_addr_out == $past(vec_addr);
    endproperty
    a_noredir: assert property (p_noredir) else $error("redirected");

    property p_redir;
        @(posedge clock) disable iff (!rst_n)
        vec_req && redir |=> vec_addr_out < prot_base
            && 16'(prot_base - vec_addr_out) <= 16'(16'h0000 - VEC_LO);
    endproperty
    a_redir: assert property (p_redir) else $error("not below");
endmodule : fsp_protect
`default_nettype wire

/* pkg/fsp_pkg.sv */
// Constants and carriers for the flash security and protection options
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package fsp_pkg;
    localparam logic [1:0] OFS_OPTION = 2'h0;
    localparam logic [1:0] OFS_CONFIG = 2'h1;
    localparam logic [1:0] OFS_PROTECT = 2'h2;
    localparam logic [1:0] OFS_STATUS = 2'h3;
    localparam logic [7:0] OPTION_RST = 8'h00;
    localparam logic [7:0] PROTECT_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] OPTION_MASK = 8'hc3;
    localparam logic [7:0] CONFIG_MASK = 8'he0;
    localparam logic [7:0] PROTECT_MASK = 8'hf8;
    localparam int KEY_EN_BIT = 7;
    localparam int NORED_BIT = 6;
    localparam int KEY_ACC_BIT = 5;
    localparam int OPEN_BIT = 7;
    localparam int PDIS_BIT = 6;
    localparam int SIZE_LSB = 3;
    localparam int VIOL_BIT = 5;
    localparam int LIFT_BIT = 1;
    localparam int SECURE_BIT = 0;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [2:0] SIZE_WHOLE = 3'h7;
    localparam logic [2:0] SIZE_16K = 3'h5;
    localparam logic [2:0] SIZE_32K = 3'h6;
    localparam logic [15:0] KEY_BASE = 16'hffb0;
    localparam logic [15:0] KEY_LAST = 16'hffb7;
    localparam logic [15:0] BLOCK_MIN = 16'h0200;
    localparam logic [15:0] WHOLE_BASE = 16'h182c;
    localparam logic [15:0] VEC_LO = 16'hffc0;
    localparam logic [15:0] VEC_HI = 16'hfffd;
    localparam logic [2:0] KEY_LAST_IDX = 3'h7;

    typedef struct packed {
        logic wr;
        logic dbg;
        logic [15:0] addr;
        logic [7:0] data;
    } fsp_flash_wr_t;

    typedef struct packed {
        logic valid;
        logic mass;
        logic [15:0] addr;
    } fsp_cmd_t;
endpackage : fsp_pkg

/* sim/fsp_nv_image.sv */
// Nonvolatile image model: option, protection and key bytes
`timescale 1ns/1ns
`default_nettype none
module fsp_nv_image #(
    parameter logic [63:0] KEY = 64'h8877665544332211
) (
    input wire logic clock,
    input wire logic prog,
    input wire logic prog_prot,
    input wire logic [7:0] prog_data,
    output logic [7:0] nv_option,
    output logic [7:0] nv_protect,
    output logic [63:0] nv_key
);
    // byte reprogram; seen only after the next reset load
    always_ff @(posedge clock) begin
        if (prog && !prog_prot) begin
            nv_option <= prog_data;
        end
        if (prog && prog_prot) begin
            nv_protect <= prog_data;
        end
    end
    assign nv_key = KEY;
endmodule : fsp_nv_image
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the flash protection options block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import fsp_pkg::*;
    logic clock, rst_n, reg_wr, reg_rd, reg_dbg, prog, prog_prot;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, prog_data, nv_opt, nv_prot;
    logic [63:0] key;
    fsp_flash_wr_t flash_wr;
    fsp_cmd_t cmd;
    logic blank_ok, mem_rd, mem_flash, mem_unsec, vec_req, secure;
    logic cmd_first_step, cmd_accept, mem_rd_deny, flash_rd_invalid;
    logic [15:0] vec_addr, vec_addr_out;
    int n_errors, samples_checked;

    fsp_nv_image fsp_nv_image_inst (.clock(clock), .prog(prog),
        .prog_prot(prog_prot), .prog_data(prog_data), .nv_option(nv_opt),
        .nv_protect(nv_prot), .nv_key(key));
    fsp_protect fsp_protect_inst (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_dbg(reg_dbg), .reg_rdata(reg_rdata),
        .nonvolatile_option_byte(nv_opt),
        .nonvolatile_protection_byte(nv_prot), .stored_backdoor_key(key),
        .flash_wr(flash_wr), .cmd_first_step(cmd_first_step), .cmd(cmd),
        .cmd_accept(cmd_accept), .blank_ok(blank_ok), .mem_rd(mem_rd),
        .mem_rd_from_flash(mem_flash), .mem_rd_src_unsecured(mem_unsec),
        .mem_rd_deny(mem_rd_deny), .flash_rd_invalid(flash_rd_invalid),
        .vec_req(vec_req), .vec_addr(vec_addr),
        .vec_addr_out(vec_addr_out), .secure(secure));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("Counts: %0d mismatches, %0d checks", n_errors,
            samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    // Nonvolatile bytes are written before release so the load sees them
    task automatic do_reset(input logic [7:0] opt, input logic [7:0] prot,
            input int n);
        @(posedge clock);
        rst_n <= 1'b0;
        prog <= 1'b1;
        prog_prot <= 1'b0;
        prog_data <= opt;
        @(posedge clock);
        prog_prot <= 1'b1;
        prog_data <= prot;
        @(posedge clock);
        prog <= 1'b0;
        repeat (n) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask : do_reset

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d,
            input logic dbg);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_dbg <= dbg;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_dbg <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_regs();
        logic [7:0] d;
        do_reset(8'hff, 8'hff, 2);
        reg_read(OFS_OPTION, d);
        check(d, 8'hc3);
        reg_write(OFS_OPTION, 8'h00, 1'b0);
        reg_read(OFS_OPTION, d);
        check(d, 8'hc3);
        reg_read(OFS_PROTECT, d);
        check(d, 8'hf8);
        reg_write(OFS_PROTECT, 8'h00, 1'b0);
        reg_read(OFS_PROTECT, d);
        check(d, 8'hf8);
        reg_write(OFS_PROTECT, 8'h4f, 1'b1);
        reg_read(OFS_PROTECT, d);
        check(d, 8'h48);
        reg_write(OFS_CONFIG, 8'hff, 1'b0);
        reg_read(OFS_CONFIG, d);
        check(d, 8'he0);
        for (int s = 0; s < 4; s++) begin
            do_reset({6'h00, 2'(s)}, 8'h00, 2);
            mem_rd <= 1'b1;
            mem_unsec <= 1'b1;
            @(posedge clock);
            #1 check(secure, s != 2);
            check(mem_rd_deny, s != 2);
            @(posedge clock);
            mem_unsec <= 1'b0;
            #1 check(mem_rd_deny, 1'b0);
        end
        @(posedge clock);
        mem_rd <= 1'b0;
        do_reset(8'h01, 8'h00, 2);
        @(posedge clock);
        blank_ok <= 1'b1;
        @(posedge clock);
        blank_ok <= 1'b0;
        #1 check(secure, 1'b0);
        reg_read(OFS_OPTION, d);
        check(d, 8'h02);
    endtask : test_regs

    task automatic key_try(input logic [7:0] opt, input logic dbg,
            input int bad, input logic exp);
        logic [7:0] d;
        do_reset(opt, 8'h00, 2);
        reg_write(OFS_CONFIG, 8'h20, 1'b0);
        // Key bytes, issued as from RAM-resident code, or as debug writes when dbg is set
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            flash_wr <= '{1'b1, dbg, KEY_BASE + 16'(i),
                key[8*i +: 8] ^ ((i == bad) ? 8'h01 : 8'h00)};
        end
        @(posedge clock);
        flash_wr.wr <= 1'b0;
        #1 check(secure, exp);
        reg_read(OFS_OPTION, d);
        check(d[1:0], exp ? opt[1:0] : SEC_UNSECURED);
        reg_read(OFS_STATUS, d);
        check(d[LIFT_BIT], !exp);
        check(d[SECURE_BIT], exp);
    endtask : key_try

    task automatic test_key_access();
        do_reset(8'h80, 8'h00, 2);
        reg_write(OFS_CONFIG, 8'h20, 1'b0);
        @(posedge clock);
        flash_wr <= '{1'b1, 1'b0, 16'hffb3, 8'h00};
        mem_rd <= 1'b1;
        mem_flash <= 1'b1;
        #1 check(cmd_first_step, 1'b0);
        check(flash_rd_invalid, 1'b1);
        @(posedge clock);
        flash_wr.wr <= 1'b0;
        reg_write(OFS_CONFIG, 8'h00, 1'b0);
        @(posedge clock);
        flash_wr.wr <= 1'b1;
        #1 check(cmd_first_step, 1'b1);
        check(flash_rd_invalid, 1'b0);
        @(posedge clock);
        flash_wr.wr <= 1'b0;
        mem_rd <= 1'b0;
    endtask : test_key_access

    task automatic cmd_try(input logic [7:0] p, input logic [15:0] a,
            input logic mass);
        logic ok;
        logic [7:0] d;
        logic [15:0] base;
        base = (p[5:3] == 3'h7) ? 16'h182c : 16'h0000 - (16'h0200 << p[5:3]);
        ok = p[7] && (p[6] || (!mass && a < base));
        reg_write(OFS_PROTECT, p, 1'b1);
        @(posedge clock);
        cmd <= '{1'b1, mass, a};
        #1 check(cmd_accept, ok);
        @(posedge clock);
        cmd.valid <= 1'b0;
        reg_read(OFS_STATUS, d);
        check(d[VIOL_BIT], !ok);
        reg_write(OFS_STATUS, 8'h20, 1'b0);
        reg_read(OFS_STATUS, d);
        check(d[VIOL_BIT], 1'b0);
    endtask : cmd_try

    task automatic test_viol_race();
        logic [7:0] d;
        reg_write(OFS_PROTECT, 8'h00, 1'b1);
        @(posedge clock);
        cmd <= '{1'b1, 1'b0, 16'h2000};
        reg_wr <= 1'b1;
        reg_addr <= OFS_STATUS;
        reg_wdata <= 8'h20;
        @(posedge clock);
        cmd.valid <= 1'b0;
        reg_wr <= 1'b0;
        reg_read(OFS_STATUS, d);
        check(d[VIOL_BIT], 1'b1);
        reg_write(OFS_STATUS, 8'h20, 1'b0);
    endtask : test_viol_race

    task automatic vec_try(input logic [7:0] p, input logic [15:0] a,
            input logic nored);
        logic [15:0] e;
        e = a;
        if (p[7] && !nored && p[5:3] != 3'h7 && a >= VEC_LO && a <= VEC_HI)
            e = a - (16'h0200 << p[5:3]);
        reg_write(OFS_PROTECT, p, 1'b1);
        @(posedge clock);
        vec_req <= 1'b1;
        vec_addr <= a;
        @(posedge clock);
        vec_req <= 1'b0;
        #1 check(vec_addr_out, e);
    endtask : vec_try

    initial begin
        repeat (100000) @(posedge clock);
        n_errors++;
        $display("Error at %0t: run did not finish", $time);
        give_verdict();
    end

    initial begin
        {rst_n, reg_wr, reg_rd, reg_dbg, prog, prog_prot} <= '0;
        {reg_addr, reg_wdata, prog_data, blank_ok, vec_req} <= '0;
        {mem_rd, mem_flash, mem_unsec, vec_addr} <= '0;
        flash_wr <= '0;
        cmd <= '0;
        n_errors = 0;
        samples_checked = 0;
        do_reset(8'h00, 8'h00, 18);
        test_regs();
        key_try(8'h80, 1'b0, -1, 1'b0);
        key_try(8'h00, 1'b0, -1, 1'b1);
        key_try(8'h80, 1'b1, -1, 1'b1);
        key_try(8'h80, 1'b0, 7, 1'b1);
        test_key_access();
        cmd_try(8'h00, 16'h2000, 1'b0);
        cmd_try(8'h80, 16'hfe00, 1'b0);
        cmd_try(8'h80, 16'hfdff, 1'b0);
        cmd_try(8'hc0, 16'hfe00, 1'b0);
        cmd_try(8'hb0, 16'h8000, 1'b0);
        cmd_try(8'hb0, 16'h7fff, 1'b0);
        cmd_try(8'hb8, 16'h182c, 1'b0);
        cmd_try(8'hb8, 16'h182b, 1'b0);
        cmd_try(8'h80, 16'h1000, 1'b1);
        cmd_try(8'hc0, 16'h1000, 1'b1);
        test_viol_race();
        vec_try(8'h80, 16'hffc0, 1'b0);
        vec_try(8'h80, 16'hfffe, 1'b0);
        vec_try(8'h80, 16'hffbe, 1'b0);
        vec_try(8'hb0, 16'hffc4, 1'b0);
        vec_try(8'ha8, 16'hfffd, 1'b0);
        vec_try(8'hb8, 16'hffc0, 1'b0);
        vec_try(8'h00, 16'hffc0, 1'b0);
        do_reset(8'h40, 8'h00, 2);
        vec_try(8'h80, 16'hffc0, 1'b1);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
